// [inc/lbpc_pkg.sv]
// Purpose: shared constants and types of the link self-test and power-down control
// Assumes: core clock of 40 MHz
// Notes:   register offsets, field positions, reset values and timing counts
package lbpc_pkg;
    // register offsets
    localparam logic [7:0] REG_GEN_CONFIG    = 8'h02;
    localparam logic [7:0] REG_TEST_CTRL     = 8'h24;
    localparam logic [7:0] REG_ERR_COUNT     = 8'h25;
    // reset values, writable masks and error count limit
    localparam logic [7:0] GEN_CONFIG_RST    = 8'h01;
    localparam logic [7:0] TEST_CTRL_RST     = 8'h08;
    localparam logic [7:0] ERR_COUNT_RST     = 8'h00;
    localparam logic [7:0] GEN_CONFIG_MASK   = 8'h01;
    localparam logic [7:0] TEST_CTRL_MASK    = 8'h0F;
    localparam logic [7:0] ERR_COUNT_MAX     = 8'hFF;
    // field positions
    localparam int STROBE_SEL_BIT    = 0;
    localparam int CTRL_REG_EN_BIT   = 0;
    localparam int CTRL_CLK_LO_BIT   = 1;
    localparam int CTRL_CLK_HI_BIT   = 2;
    localparam int CTRL_PIN_SEL_BIT  = 3;
    // test clock codes, pin encoding
    localparam logic [1:0] TCLK_EXTERNAL     = 2'h0;
    localparam logic [1:0] TCLK_25MHZ        = 2'h1;
    localparam logic [1:0] TCLK_50MHZ        = 2'h2;
    localparam logic [1:0] TCLK_12M5         = 2'h3;
    // control port address, default value
    localparam logic [6:0] I2C_DEV_ADDR      = 7'h60;
    // timing, synchroniser width
    localparam int CLK_PERIOD_NS     = 25;
    localparam int PASS_PULSE_NS     = 50;
    localparam int RESULT_SHOW_NS    = 2000;
    localparam logic [7:0] PASS_PULSE_CYCLES =
        8'((PASS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESULT_CYCLES     =
        8'(RESULT_SHOW_NS / CLK_PERIOD_NS);
    localparam int SYNC_WIDTH        = 17;

    typedef enum logic [2:0] {
        TS_OFF       = 3'b000,
        TS_WAIT_LOCK = 3'b001,
        TS_CHECK     = 3'b010,
        TS_RESULT    = 3'b011
    } lbpc_test_state_type;

    typedef enum logic [2:0] {
        IS_IDLE  = 3'b000,
        IS_ADDR  = 3'b001,
        IS_ACK_A = 3'b010,
        IS_PTR   = 3'b011,
        IS_ACK_P = 3'b100,
        IS_WDATA = 3'b101,
        IS_RDATA = 3'b110,
        IS_RACK  = 3'b111
    } lbpc_i2c_state_type;
endpackage

// [hw/lbpc_sync.sv]
// Purpose: two-flop synchroniser for a bundle of outside levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lbpc_sync
    import lbpc_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // lbpc_sync
`default_nettype wire

// [hw/lbpc_i2c_slave.sv]
// Purpose: byte register slave on the two-wire control port
// Assumes: scl and sda already synchronised to the core clock
// Notes:   pointer byte then data bytes, pointer auto-increments
`timescale 1ns/1ps
`default_nettype none
module lbpc_i2c_slave
    import lbpc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [7:0] rd_data_in,
    output var  logic       sda_oe_out,
    output var  logic       wr_en_out,
    output var  logic [7:0] wr_data_out,
    output var  logic [7:0] addr_out
);
    lbpc_i2c_state_type st;
    logic       scl_q;
    logic       sda_q;
    logic       is_read;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st          <= IS_IDLE;
            is_read     <= 1'b0;
            bit_cnt     <= 4'h0;
            shreg       <= 8'h00;
            tx          <= 8'h00;
            sda_oe_out  <= 1'b0;
            wr_en_out   <= 1'b0;
            wr_data_out <= 8'h00;
            addr_out    <= 8'h00;
        end else begin
            wr_en_out <= 1'b0;
            if (start_seen) begin
                st         <= IS_ADDR;
                bit_cnt    <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (stop_seen) begin
                st         <= IS_IDLE;
                sda_oe_out <= 1'b0;
            end else if (scl_rise) begin
                case (st)
                    IS_ADDR, IS_PTR, IS_WDATA: begin
                        shreg   <= {shreg[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    IS_RDATA: bit_cnt <= bit_cnt + 4'h1;
                    IS_RACK: begin
                        if (sda_in) begin
                            st <= IS_IDLE;
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (st)
                    IS_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == I2C_DEV_ADDR) begin
                                sda_oe_out <= 1'b1;
                                is_read    <= shreg[0];
                                st         <= IS_ACK_A;
                            end else begin
                                st <= IS_IDLE;
                            end
                        end
                    end
                    IS_ACK_A, IS_RACK: begin
                        bit_cnt <= 4'h0;
                        if (is_read) begin
                            tx         <= rd_data_in;
                            sda_oe_out <= ~rd_data_in[7];
                            st         <= IS_RDATA;
                        end else begin
                            sda_oe_out <= 1'b0;
                            st         <= IS_PTR;
                        end
                    end
                    IS_PTR: begin
                        if (bit_cnt == 4'h8) begin
                            addr_out   <= shreg;
                            sda_oe_out <= 1'b1;
                            st         <= IS_ACK_P;
                        end
                    end
                    IS_ACK_P: begin
                        sda_oe_out <= 1'b0;
                        bit_cnt    <= 4'h0;
                        st         <= IS_WDATA;
                    end
                    IS_WDATA: begin
                        if (bit_cnt == 4'h8) begin
                            wr_en_out   <= 1'b1;
                            wr_data_out <= shreg;
                            sda_oe_out  <= 1'b1;
                            st          <= IS_ACK_P;
                        end else if (bit_cnt == 4'h0) begin
                            sda_oe_out <= 1'b0;
                        end
                    end
                    IS_RDATA: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe_out <= 1'b0;
                            addr_out   <= addr_out + 8'h01;
                            st         <= IS_RACK;
                        end else begin
                            tx         <= {tx[6:0], 1'b0};
                            sda_oe_out <= ~tx[6];
                        end
                    end
                    default: ;
                endcase
            end
            if (wr_en_out) begin
                addr_out <= addr_out + 8'h01;
            end
        end
    end
endmodule // lbpc_i2c_slave
`default_nettype wire

// [hw/lbpc_top.sv]
// Purpose: power-down, strobe edge select and at-speed link self test control
// Assumes: single 40 MHz core clock; link clock sampled as a level
// Notes:   registers reached over the two-wire control port
`timescale 1ns/1ps
`default_nettype none
module lbpc_top
    import lbpc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       power_down_n_pin_in,
    input  wire logic       self_test_enable_pin_in,
    input  wire logic [1:0] test_clk_sel_pin_in,
    input  wire logic       link_clk_in,
    input  wire logic       link_lock_in,
    input  wire logic       link_frame_err_in,
    input  wire logic [7:0] link_data_in,
    input  wire logic       i2c_scl_in,
    input  wire logic       i2c_sda_in,
    output var  logic       i2c_sda_out,
    output var  logic       i2c_sda_oe_out,
    output var  logic       lock_out,
    output var  logic       lock_oe_out,
    output var  logic       pass_out,
    output var  logic       pass_oe_out,
    output var  logic       sck_out,
    output var  logic       sck_oe_out,
    output var  logic [7:0] audio_data_out,
    output var  logic       audio_data_oe_out,
    output var  logic       back_channel_start_out,
    output var  logic       link_self_test_active_out,
    output var  logic [1:0] test_clk_code_out
);
    logic [SYNC_WIDTH-1:0] raw_bus;
    logic [SYNC_WIDTH-1:0] sync_bus;
    logic                  pdn_s;
    logic                  test_pin_s;
    logic [1:0]            clk_pin_s;
    logic                  link_clk_s;
    logic                  lock_s;
    logic                  frame_err_s;
    logic [7:0]            data_s;
    logic                  scl_s;
    logic                  sda_s;
    logic                  rst_all;
    logic                  link_clk_q;
    logic                  link_rise;
    logic                  link_fall;
    logic                  launch;
    logic [7:0]            gen_config;
    logic [7:0]            test_ctrl;
    logic [7:0]            err_count;
    logic [7:0]            rd_data;
    logic                  wr_en;
    logic [7:0]            wr_data;
    logic [7:0]            reg_addr;
    logic                  test_en;
    logic                  test_en_q;
    logic                  session_start;
    lbpc_test_state_type   st;
    logic [7:0]            pulse_cnt;
    logic [7:0]            show_cnt;
    logic                  next_pass;
    logic [1:0]            next_clk_code;

    assign raw_bus = {i2c_sda_in,
                      i2c_scl_in,
                      link_data_in,
                      link_frame_err_in,
                      link_lock_in,
                      link_clk_in,
                      test_clk_sel_pin_in,
                      self_test_enable_pin_in,
                      power_down_n_pin_in};

    lbpc_sync #(
        .WIDTH (SYNC_WIDTH)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .async_in    (raw_bus),
        .sync_out    (sync_bus)
    );

    assign pdn_s       = sync_bus[0];
    assign test_pin_s  = sync_bus[1];
    assign clk_pin_s   = sync_bus[3:2];
    assign link_clk_s  = sync_bus[4];
    assign lock_s      = sync_bus[5];
    assign frame_err_s = sync_bus[6];
    assign data_s      = sync_bus[14:7];
    assign scl_s       = sync_bus[14+1];
    assign sda_s       = sync_bus[SYNC_WIDTH-1];

    // power-down acts as a reset of all control state
    assign rst_all = sys_rst_in | ~pdn_s;

    lbpc_i2c_slave u_i2c (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_all),
        .scl_in      (scl_s),
        .sda_in      (sda_s),
        .rd_data_in  (rd_data),
        .sda_oe_out  (i2c_sda_oe_out),
        .wr_en_out   (wr_en),
        .wr_data_out (wr_data),
        .addr_out    (reg_addr)
    );

    // open drain, only ever pulls low
    always_ff @(posedge core_clk_in) begin
        i2c_sda_out <= 1'b0;
    end

    // register writes
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            gen_config <= GEN_CONFIG_RST;
            test_ctrl  <= TEST_CTRL_RST;
        end else if (wr_en) begin
            if (reg_addr == REG_GEN_CONFIG) begin
                gen_config <= wr_data & GEN_CONFIG_MASK;
            end
            if (reg_addr == REG_TEST_CTRL) begin
                test_ctrl <= wr_data & TEST_CTRL_MASK;
            end
        end
    end

    // register reads
    always_comb begin
        case (reg_addr)
            REG_GEN_CONFIG: rd_data = gen_config;
            REG_TEST_CTRL:  rd_data = test_ctrl;
            REG_ERR_COUNT:  rd_data = err_count;
            default:        rd_data = 8'h00;
        endcase
    end

    // link clock edge detection
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            link_clk_q <= 1'b0;
        end else begin
            link_clk_q <= link_clk_s;
        end
    end

    assign link_rise = link_clk_s & ~link_clk_q;
    assign link_fall = ~link_clk_s & link_clk_q;

    // data changes on the edge opposite the capture edge
    assign launch = gen_config[STROBE_SEL_BIT] ? link_fall : link_rise;

    // output clock and data path
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            sck_out        <= 1'b0;
            audio_data_out <= 8'h00;
        end else begin
            sck_out <= link_clk_s;
            if (launch && lock_s) begin
                audio_data_out <= data_s;
            end
        end
    end

    // lock indication
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            lock_out <= 1'b0;
        end else begin
            lock_out <= lock_s;
        end
    end

    // output enables follow power-down
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            lock_oe_out       <= 1'b0;
            pass_oe_out       <= 1'b0;
            sck_oe_out        <= 1'b0;
            audio_data_oe_out <= 1'b0;
        end else begin
            lock_oe_out       <= pdn_s;
            pass_oe_out       <= pdn_s;
            sck_oe_out        <= pdn_s;
            audio_data_oe_out <= pdn_s;
        end
    end

    // test enable from pin or register
    assign test_en = test_pin_s | test_ctrl[CTRL_REG_EN_BIT];

    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            test_en_q <= 1'b0;
        end else begin
            test_en_q <= test_en;
        end
    end

    assign session_start = test_en & ~test_en_q;

    // self-test sequence
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            st        <= TS_OFF;
            err_count <= ERR_COUNT_RST;
            pulse_cnt <= 8'h00;
            show_cnt  <= 8'h00;
        end else begin
            if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
            case (st)
                TS_OFF, TS_RESULT: begin
                    if (session_start) begin
                        err_count <= ERR_COUNT_RST;
                        show_cnt  <= 8'h00;
                        st        <= TS_WAIT_LOCK;
                    end else if (st == TS_RESULT) begin
                        if (show_cnt <= 8'h01) begin
                            show_cnt <= 8'h00;
                            st       <= TS_OFF;
                        end else begin
                            show_cnt <= show_cnt - 8'h01;
                        end
                    end
                end
                TS_WAIT_LOCK: begin
                    if (!test_en) begin
                        show_cnt <= RESULT_CYCLES;
                        st       <= TS_RESULT;
                    end else if (lock_s) begin
                        st <= TS_CHECK;
                    end
                end
                TS_CHECK: begin
                    if (!test_en) begin
                        pulse_cnt <= 8'h00;
                        show_cnt  <= RESULT_CYCLES;
                        st        <= TS_RESULT;
                    end else if (link_rise && frame_err_s) begin
                        pulse_cnt <= PASS_PULSE_CYCLES;
                        if (err_count != ERR_COUNT_MAX) begin
                            err_count <= err_count + 8'h01;
                        end
                    end
                end
                default: st <= TS_OFF;
            endcase
        end
    end

    // start command over the back channel
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            back_channel_start_out <= 1'b0;
        end else begin
            back_channel_start_out <= session_start &&
                                      (st == TS_OFF || st == TS_RESULT);
        end
    end

    // test mode level towards the serializer
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            link_self_test_active_out <= 1'b0;
        end else begin
            link_self_test_active_out <= test_en;
        end
    end

    // result pin
    always_comb begin
        case (st)
            TS_OFF:       next_pass = lock_s;
            TS_WAIT_LOCK: next_pass = 1'b0;
            TS_CHECK:     next_pass = (pulse_cnt == 8'h00);
            TS_RESULT:    next_pass = (err_count == ERR_COUNT_RST);
            default:      next_pass = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            pass_out <= 1'b0;
        end else begin
            pass_out <= next_pass;
        end
    end

    // test clock source selection, normalised to pin encoding
    always_comb begin
        next_clk_code = TCLK_EXTERNAL;
        if (test_en) begin
            if (test_ctrl[CTRL_PIN_SEL_BIT]) begin
                next_clk_code = clk_pin_s;
            end else begin
                case (test_ctrl[CTRL_CLK_HI_BIT:CTRL_CLK_LO_BIT])
                    2'h1:    next_clk_code = TCLK_50MHZ;
                    2'h2:    next_clk_code = TCLK_25MHZ;
                    2'h3:    next_clk_code = TCLK_12M5;
                    default: next_clk_code = TCLK_EXTERNAL;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            test_clk_code_out <= TCLK_EXTERNAL;
        end else begin
            test_clk_code_out <= next_clk_code;
        end
    end
endmodule // lbpc_top
`default_nettype wire

// [sim/lbpc_props.sv]
// Purpose: assertions on the ports of lbpc_top
// Assumes: one core clock domain
// Notes:   figures follow the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module lbpc_props (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic power_down_n_pin_in,
    input wire logic self_test_enable_pin_in,
    input wire logic link_clk_in,
    input wire logic link_lock_in,
    input wire logic link_frame_err_in,
    input wire logic lock_out,
    input wire logic lock_oe_out,
    input wire logic pass_out,
    input wire logic pass_oe_out,
    input wire logic back_channel_start_out,
    input wire logic link_self_test_active_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_pd_tristate: assert property (!power_down_n_pin_in [*4] |->
        !lock_oe_out && !pass_oe_out) else $error("output driven in power-down");
    chk_rst_clears: assert property (disable iff (1'b0) sys_rst_in |=>
        !pass_oe_out && !back_channel_start_out) else $error("state kept in reset");
    chk_lock_follows: assert property ((power_down_n_pin_in && link_lock_in) [*5] |->
        lock_out && lock_oe_out) else $error("lock not driven");
    chk_enable_starts: assert property ($rose(self_test_enable_pin_in) &&
        power_down_n_pin_in && !link_self_test_active_out |-> ##[2:5] back_channel_start_out)
        else $error("no start after enable");
    chk_start_single: assert property (back_channel_start_out |=>
        !back_channel_start_out && link_self_test_active_out) else $error("start not a pulse");
    chk_lock_pass_high: assert property ($rose(link_self_test_active_out) && lock_out |->
        ##[1:12] pass_out) else $error("pass not high after lock");
    chk_err_pulse: assert property ($rose(link_clk_in) && link_frame_err_in && pass_out &&
        link_self_test_active_out |-> ##[3:6] (!pass_out ##1 !pass_out ##1 pass_out))
        else $error("errored frame pulse wrong");
    chk_result_brief: assert property ($fell(link_self_test_active_out) && lock_out |->
        ##[85:100] pass_out) else $error("result held too long");
    cover property (back_channel_start_out);
    cover property ($fell(pass_out) && link_self_test_active_out);
    cover property ($fell(link_self_test_active_out) && !pass_out);
endmodule // lbpc_props
bind lbpc_top lbpc_props lbpc_props_inst (.core_clk_in, .sys_rst_in, .power_down_n_pin_in,
    .self_test_enable_pin_in, .link_clk_in, .link_lock_in, .link_frame_err_in, .lock_out,
    .lock_oe_out, .pass_out, .pass_oe_out, .back_channel_start_out, .link_self_test_active_out);
`default_nettype wire

// [sim/lbpc_partner.sv]
// Purpose: serializer side: link clock, lock, data, test pattern errors
// Assumes: link clock of 200 ns while locked, still otherwise
// Notes:   err_n_in errored frames after each start command
`timescale 1ns/1ps
`default_nettype none
module lbpc_partner (
    input  wire logic       pd_n_in,
    input  wire logic       start_in,
    input  wire logic [8:0] err_n_in,
    output var  logic       link_clk_out,
    output var  logic       lock_out,
    output var  logic       frame_err_out,
    output var  logic [7:0] data_out
);
    initial {link_clk_out, lock_out, frame_err_out, data_out} = '0;
    always @(pd_n_in) begin
        if (!pd_n_in) lock_out = 1'b0;
        else lock_out <= #1000 1'b1;
    end
    always #100 begin
        if (lock_out) link_clk_out = ~link_clk_out;
        else link_clk_out = 1'b0;
        if (!lock_out) data_out = ~data_out;
        else if (link_clk_out) data_out = data_out + 8'h35;
    end
    always @(posedge start_in) begin
        repeat (4) @(posedge link_clk_out);
        if (err_n_in != 9'h000) begin
            @(negedge link_clk_out) frame_err_out = 1'b1;
            repeat (err_n_in) @(posedge link_clk_out);
            @(negedge link_clk_out) frame_err_out = 1'b0;
        end
    end
endmodule // lbpc_partner
`default_nettype wire

// [sim/lbpc_top_tb.sv]
// Purpose: self-checking bench of lbpc_top
// Assumes: inputs driven on the falling clock edge
// Notes:   registers reached over the two-wire port
`timescale 1ns/1ps
`default_nettype none
module lbpc_top_tb;
    import lbpc_pkg::*;
    logic       clk = 0, rst = 1, pd_n = 0, ten = 0, scl = 1, sda = 1, ak;
    logic [1:0] tsel = 2'h0;
    logic [8:0] err_n = 9'h000;
    int         err_total = 0, checks_done = 0, cyc = 0, npulse = 0;
    wire logic  lclk, lck, fer, sda_oe, lock_o, lock_oe, pass_o, pass_oe, sck_o, sck_oe;
    wire logic  data_oe, start, act, sda_o;
    wire logic [7:0] ldat, adat;
    wire logic [1:0] code;
    wire logic  sda_w = sda & ~sda_oe;
    lbpc_top lbpc_top_inst (
        .core_clk_in(clk), .sys_rst_in(rst), .power_down_n_pin_in(pd_n),
        .self_test_enable_pin_in(ten), .test_clk_sel_pin_in(tsel), .link_clk_in(lclk),
        .link_lock_in(lck), .link_frame_err_in(fer), .link_data_in(ldat), .i2c_scl_in(scl),
        .i2c_sda_in(sda_w), .i2c_sda_out(sda_o), .i2c_sda_oe_out(sda_oe), .lock_out(lock_o),
        .lock_oe_out(lock_oe), .pass_out(pass_o), .pass_oe_out(pass_oe), .sck_out(sck_o),
        .sck_oe_out(sck_oe), .audio_data_out(adat), .audio_data_oe_out(data_oe),
        .back_channel_start_out(start), .link_self_test_active_out(act), .test_clk_code_out(code));
    lbpc_partner lbpc_partner_inst (.pd_n_in(pd_n), .start_in(start), .err_n_in(err_n),
        .link_clk_out(lclk), .lock_out(lck), .frame_err_out(fer), .data_out(ldat));
    initial forever #12.5 clk = ~clk;
    always @(negedge pass_o) if (act) npulse++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic ph(input logic c, input logic d);
        cy(5);
        scl = c;
        sda = d;
    endtask
    task automatic st;
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    task automatic xb(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            ph(1'b0, w[i]);
            ph(1'b1, w[i]);
            r[i] = sda_w;
        end
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ak = sda_w;
        ph(1'b0, 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        st();
        xb({I2C_DEV_ADDR, 1'b0}, r);
        xb(a, r);
        xb(d, r);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        st();
        xb({I2C_DEV_ADDR, 1'b0}, r);
        cmp("address ack", 9'h000, {8'h00, ak});
        xb(a, r);
        st();
        xb({I2C_DEV_ADDR, 1'b1}, r);
        xb(8'hFF, r);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        cmp(n, {1'b0, e}, {1'b0, r});
    endtask
    task automatic sess(input logic [8:0] n);
        err_n = n;
        ten = 1'b1;
        cy(30);
        npulse = 0;
        cy(8 * n + 120);
        cmp("error pulses", n, 9'(npulse));
        ten = 1'b0;
        cy(10);
        cmp("result pin", {8'h00, n == 9'h000}, {8'h00, pass_o});
        cy(90);
        cmp("pass after result", 9'h001, {8'h00, pass_o});
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        cy(20);
        cmp("oe in power-down", 9'h000, {4'h0, sda_o, lock_oe, pass_oe, sck_oe, data_oe});
        pd_n = 1'b1;
        cy(60);
        cmp("lock after power-up", 9'h00F, {5'h00, lock_o, lock_oe, sck_oe, data_oe});
        rc("control reset", REG_TEST_CTRL, TEST_CTRL_RST);
        rc("count reset", REG_ERR_COUNT, ERR_COUNT_RST);
        rc("unmapped", 8'h30, 8'h00);
        wr(REG_TEST_CTRL, 8'hF6);
        wr(REG_ERR_COUNT, 8'h5A);
        rc("control written", REG_TEST_CTRL, 8'h06);
        rc("count read-only", REG_ERR_COUNT, 8'h00);
        pd_n = 1'b0;
        cy(10);
        pd_n = 1'b1;
        cy(60);
        rc("control after power-down", REG_TEST_CTRL, TEST_CTRL_RST);
        $display("test power and registers done");
        for (int k = 0; k < 4; k++) begin
            tsel = 2'(k);
            ten = 1'b1;
            cy(10);
            cmp("pin clock code", 9'(k), {7'h00, code});
            ten = 1'b0;
            cy(100);
            tsel = ~tsel;
            wr(REG_TEST_CTRL, {5'h00, 2'(k), 1'b1});
            cy(10);
            cmp("register clock code", {7'h00, ~tsel[0], ~tsel[1]}, {7'h00, code});
            wr(REG_TEST_CTRL, TEST_CTRL_RST);
            cy(100);
        end
        $display("test clock select done");
        sess(9'h003);
        rc("error count", REG_ERR_COUNT, 8'h03);
        sess(9'h000);
        rc("count cleared", REG_ERR_COUNT, 8'h00);
        sess(9'h12C);
        rc("count saturated", REG_ERR_COUNT, ERR_COUNT_MAX);
        $display("test self-test sessions done");
        @(adat);
        #1;
        cmp("launch at strobe 1", {ldat, 1'b0}, {adat, sck_o});
        wr(REG_GEN_CONFIG, 8'h00);
        @(adat);
        #1;
        cmp("launch at strobe 0", {ldat, 1'b1}, {adat, sck_o});
        $display("test strobe edge done");
        finish_test();
    end
endmodule // lbpc_top_tb
`default_nettype wire
